// ---- shared/cbbc_pkg.sv ----
package cbbc_pkg;

  // ==========================================================================
  // configuration space placement
  // ==========================================================================
  localparam logic [7:0] CBBC_CTRL_OFFSET = 8'h3E;
  localparam logic [2:0] CBBC_FUNC_NUM = 3'h0;
  localparam int CBBC_CTRL_W = 16;
  localparam int CBBC_CFG_W = 32;

  // ==========================================================================
  // field positions and masks
  // ==========================================================================
  localparam int CBBC_B_POST = 10;
  localparam int CBBC_B_PREF1 = 9;
  localparam int CBBC_B_PREF0 = 8;
  localparam int CBBC_B_IRQSEL = 7;
  localparam int CBBC_B_CARD_RESET_N = 6;
  localparam int CBBC_B_MABT = 5;
  localparam int CBBC_B_VGA = 3;
  localparam int CBBC_B_ISA = 2;
  localparam int CBBC_B_SERR = 1;
  localparam int CBBC_B_PERR = 0;

  localparam logic [15:0] CBBC_CTRL_RESET = 16'h0340;
  // bits 15..11 and 4 are read-only zero
  localparam logic [15:0] CBBC_CTRL_WMASK = 16'h07EF;
  localparam logic [15:0] CBBC_CARD_RESET_N_MASK = 16'h0040;
  localparam logic [15:0] CBBC_NO_MASK = 16'h0000;

  // ==========================================================================
  // legacy address ranges
  // ==========================================================================
  localparam logic [31:0] CBBC_VGA_MEM_LO = 32'h000A_0000;
  localparam logic [31:0] CBBC_VGA_MEM_HI = 32'h000B_FFFF;
  localparam logic [9:0] CBBC_VGA_IO0_LO = 10'h3B0;
  localparam logic [9:0] CBBC_VGA_IO0_HI = 10'h3BB;
  localparam logic [9:0] CBBC_VGA_IO1_LO = 10'h3C0;
  localparam logic [9:0] CBBC_VGA_IO1_HI = 10'h3DF;
  localparam logic [15:0] CBBC_ISA_PAGE = 16'h0000;
  localparam logic [1:0] CBBC_ISA_FIRST_QTR = 2'h0;
  localparam int CBBC_IRQ_LINES = 16;

  // ==========================================================================
  // byte-lane merge of a config write into a 16-bit register half
  // ==========================================================================
  function automatic logic [15:0] cbbc_merge(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] be,
    input logic [15:0] wmask
  );
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_val & ~lane) | (new_val & lane);
  endfunction

endpackage

// ---- verilog/cbbc_io_filter.sv ----
module cbbc_io_filter
  import cbbc_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic is_io,
  input wire logic in_window,
  input wire logic vga_en,
  input wire logic isa_en,
  output logic to_card
);

  logic vga_hit;
  logic isa_alias;

  always_comb
  begin
    if (is_io)
    begin
      // vga ports alias through every 1K block of the low 64K, so bits 15..10 are ignored
      vga_hit = (addr[31:16] == CBBC_ISA_PAGE) &&
        (((addr[9:0] >= CBBC_VGA_IO0_LO) && (addr[9:0] <= CBBC_VGA_IO0_HI)) ||
         ((addr[9:0] >= CBBC_VGA_IO1_LO) && (addr[9:0] <= CBBC_VGA_IO1_HI)));
    end
    else
    begin
      vga_hit = (addr >= CBBC_VGA_MEM_LO) && (addr <= CBBC_VGA_MEM_HI);
    end
    isa_alias = is_io && (addr[31:16] == CBBC_ISA_PAGE) &&
      (addr[9:8] != CBBC_ISA_FIRST_QTR);
    // vga forwarding wins over the isa alias filter
    if (vga_en && vga_hit)
    begin
      to_card = 1'b1;
    end
    else if (isa_en && isa_alias)
    begin
      to_card = 1'b0;
    end
    else
    begin
      to_card = in_window;
    end
  end

endmodule // cbbc_io_filter

// ---- verilog/cbbc_irq_route.sv ----
module cbbc_irq_route
  import cbbc_pkg::*;
(
  input wire logic card_irq_request,
  input wire logic route_select,
  input wire logic [3:0] legacy_irq_num,
  output logic pci_int_req,
  output logic [CBBC_IRQ_LINES-1:0] legacy_irq_req
);

  always_comb
  begin
    pci_int_req = card_irq_request && !route_select;
    legacy_irq_req = '0;
    if (card_irq_request && route_select)
    begin
      legacy_irq_req[legacy_irq_num] = 1'b1;
    end
  end

endmodule // cbbc_irq_route

// ---- verilog/cbbc_bridge_ctrl.sv ----
// Functional notes
// - bits 15 to 11 are reserved and always read zero.
// - bit 10 enables write posting both ways through the socket.
// - with posting on, burst writes may post; others need not.
// - bit 9 marks memory window 1 prefetchable; resets to one.
// - bit 8 marks memory window 0 prefetchable; resets to one.
// - bit 7 routes card interrupts to pci lines or the legacy irq.
// - bit 6 drives card reset; resets to one, card starts held.
// - an asserted host reset also asserts card reset.
// - host reset never changes the card reset bit; global reset sets it back to one.
// - context bits survive host reset while power events are enabled.
// - bit 5 reports card master aborts as target abort and serr.
// - bit 4 is reserved and always reads zero.
// - bit 3 forwards vga address ranges to the card.
// - bit 2 blocks the upper 768 bytes of each low 1K io block.
// - bit 1 forwards card system error to pci serr.
// - bit 0 reports card parity errors on the card parity error line.
// - the register sits at config offset 3Eh, function 0, reset 0340h.
module cbbc_bridge_ctrl
  import cbbc_pkg::*;
#(
  parameter logic [15:0] CONTEXT_MASK = 16'h0040
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic global_reset_n,
  input wire logic host_reset_n,
  input wire logic power_mgmt_event,
  input wire logic [2:0] cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [CBBC_CFG_W-1:0] cfg_wdata,
  output logic [CBBC_CFG_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic write_post_enable,
  output logic window1_prefetchable,
  output logic window0_prefetchable,
  input wire logic burst_write_req,
  output logic post_write_grant,
  input wire logic fwd_valid,
  input wire logic [31:0] fwd_addr,
  input wire logic fwd_is_io,
  input wire logic fwd_in_window,
  output logic fwd_done,
  output logic fwd_to_card,
  input wire logic card_irq_request,
  input wire logic [3:0] legacy_irq_num,
  output logic pci_int_req,
  output logic [CBBC_IRQ_LINES-1:0] legacy_irq_req,
  output logic card_reset_n,
  input wire logic serr_enable,
  input wire logic card_master_abort,
  output logic pci_target_abort,
  input wire logic card_system_error_n,
  output logic pci_serr_n,
  input wire logic card_parity_detect,
  output logic card_parity_error_n
);
  import cbbc_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [CBBC_CTRL_W-1:0] ctrl;
    logic [CBBC_CFG_W-1:0] rdata;
    logic rvalid;
    logic fwd_done;
    logic fwd_card;
    logic tabort;
    logic serr;
    logic perr;
    logic card_rst;
    logic pci_int;
    logic [CBBC_IRQ_LINES-1:0] legacy_irq;
  } cbbc_state_t;

  localparam cbbc_state_t CBBC_STATE_RESET = '{
    ctrl: CBBC_CTRL_RESET,
    rdata: '0,
    rvalid: 1'b0,
    fwd_done: 1'b0,
    fwd_card: 1'b0,
    tabort: 1'b0,
    serr: 1'b0,
    perr: 1'b0,
    card_rst: 1'b1,
    pci_int: 1'b0,
    legacy_irq: '0
  };

  cbbc_state_t s_q;
  cbbc_state_t s_d;

  logic hit;
  logic [15:0] keep_mask;
  logic [15:0] ctrl_after_reset;
  logic [15:0] wr_half;
  logic [1:0] wr_be;
  logic filt_to_card;
  logic route_pci;
  logic [CBBC_IRQ_LINES-1:0] route_legacy;
  logic serr_event;

  // ==========================================================================
  // config decode
  // ==========================================================================
  always_comb
  begin
    // the register is the upper half of the dword at 3Ch
    hit = (cfg_func == CBBC_FUNC_NUM) &&
      (cfg_addr[7:2] == CBBC_CTRL_OFFSET[7:2]);
    if (CBBC_CTRL_OFFSET[1])
    begin
      wr_half = cfg_wdata[31:16];
      wr_be = cfg_byte_en[3:2];
    end
    else
    begin
      wr_half = cfg_wdata[15:0];
      wr_be = cfg_byte_en[1:0];
    end
  end

  // ==========================================================================
  // host reset retention
  // ==========================================================================
  always_comb
  begin
    // the card reset bit always survives host reset; the other
    // context bits only while power events are armed
    keep_mask = CBBC_CARD_RESET_N_MASK;
    if (power_mgmt_event)
    begin
      keep_mask = keep_mask | CONTEXT_MASK;
    end
    ctrl_after_reset = (CBBC_CTRL_RESET & ~keep_mask) |
      (s_q.ctrl & keep_mask);
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  cbbc_io_filter u_io_filter (
    .addr(fwd_addr),
    .is_io(fwd_is_io),
    .in_window(fwd_in_window),
    .vga_en(s_q.ctrl[CBBC_B_VGA]),
    .isa_en(s_q.ctrl[CBBC_B_ISA]),
    .to_card(filt_to_card)
  );

  cbbc_irq_route u_irq_route (
    .card_irq_request(card_irq_request),
    .route_select(s_q.ctrl[CBBC_B_IRQSEL]),
    .legacy_irq_num(legacy_irq_num),
    .pci_int_req(route_pci),
    .legacy_irq_req(route_legacy)
  );

  // ==========================================================================
  // error events
  // ==========================================================================
  always_comb
  begin
    serr_event = 1'b0;
    if (card_master_abort && s_q.ctrl[CBBC_B_MABT])
    begin
      serr_event = 1'b1;
    end
    if (!card_system_error_n && s_q.ctrl[CBBC_B_SERR])
    begin
      serr_event = 1'b1;
    end
    // pci serr enable gates every serr source
    serr_event = serr_event && serr_enable;
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.fwd_done = 1'b0;

    if (!global_reset_n)
    begin
      s_d.ctrl = CBBC_CTRL_RESET;
    end
    else if (!host_reset_n)
    begin
      // config cycles are ignored while the host holds reset
      s_d.ctrl = ctrl_after_reset;
    end
    else if (cfg_wr && hit)
    begin
      // reserved bits are masked out of the merge
      s_d.ctrl = cbbc_merge(s_q.ctrl, wr_half, wr_be,
        CBBC_CTRL_WMASK);
    end

    if (cfg_rd && host_reset_n && global_reset_n)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata = '0;
      if (hit)
      begin
        if (CBBC_CTRL_OFFSET[1])
        begin
          s_d.rdata[31:16] = s_q.ctrl & CBBC_CTRL_WMASK;
        end
        else
        begin
          s_d.rdata[15:0] = s_q.ctrl & CBBC_CTRL_WMASK;
        end
      end
    end

    if (fwd_valid)
    begin
      s_d.fwd_done = 1'b1;
      s_d.fwd_card = filt_to_card;
    end

    s_d.pci_int = route_pci;
    s_d.legacy_irq = route_legacy;

    s_d.tabort = card_master_abort && s_q.ctrl[CBBC_B_MABT];
    s_d.serr = serr_event;
    s_d.perr = card_parity_detect && s_q.ctrl[CBBC_B_PERR];

    // card reset follows the register bit and a passed-through host reset
    s_d.card_rst = s_d.ctrl[CBBC_B_CARD_RESET_N] || !host_reset_n;
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= CBBC_STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign cfg_rdata = s_q.rdata;
  assign cfg_rvalid = s_q.rvalid;
  assign write_post_enable = s_q.ctrl[CBBC_B_POST];
  // only burst writes are offered for posting; single writes stay delayed
  assign post_write_grant = burst_write_req && s_q.ctrl[CBBC_B_POST];
  assign window1_prefetchable = s_q.ctrl[CBBC_B_PREF1];
  assign window0_prefetchable = s_q.ctrl[CBBC_B_PREF0];
  assign fwd_done = s_q.fwd_done;
  assign fwd_to_card = s_q.fwd_card;
  assign pci_int_req = s_q.pci_int;
  assign legacy_irq_req = s_q.legacy_irq;
  assign card_reset_n = !s_q.card_rst;
  assign pci_target_abort = s_q.tabort;
  assign pci_serr_n = !s_q.serr;
  assign card_parity_error_n = !s_q.perr;

endmodule // cbbc_bridge_ctrl

// ---- tb/cbbc_bridge_ctrl_asserts.sv ----
module cbbc_bridge_ctrl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic global_reset_n,
  input wire logic host_reset_n,
  input wire logic cfg_rd,
  input wire logic [cbbc_pkg::CBBC_CFG_W-1:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic write_post_enable,
  input wire logic burst_write_req,
  input wire logic post_write_grant,
  input wire logic fwd_valid,
  input wire logic fwd_done,
  input wire logic card_reset_n,
  input wire logic serr_enable,
  input wire logic card_master_abort,
  input wire logic pci_target_abort,
  input wire logic card_system_error_n,
  input wire logic pci_serr_n,
  input wire logic card_parity_detect,
  input wire logic card_parity_error_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import cbbc_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // =====
  // sequences
  // =====
  sequence s_rd_take;
    cfg_rd && global_reset_n && host_reset_n;
  endsequence
  sequence s_host_hold;
    !host_reset_n [*2];
  endsequence
  // =====
  // properties
  // =====
  a_rd_answer: assert property (s_rd_take |=> cfg_rvalid)
    else $error("config read got no answer");
  a_rsvd_zero: assert property (cfg_rvalid |-> !cfg_rdata[31:27] && !cfg_rdata[20])
    else $error("reserved bits read nonzero");
  a_post_grant: assert property (post_write_grant == (burst_write_req && write_post_enable))
    else $error("posting grant wrong");
  a_host_card_reset_n: assert property (s_host_hold |-> !card_reset_n)
    else $error("card reset not held under host reset");
  a_abort_cause: assert property (pci_target_abort |-> $past(card_master_abort))
    else $error("target abort without master abort");
  a_serr_cause: assert property (!pci_serr_n |-> $past(serr_enable) &&
    ($past(card_master_abort) || !$past(card_system_error_n))) else $error("serr without cause");
  a_parity_cause: assert property (!card_parity_error_n |-> $past(card_parity_detect))
    else $error("parity error without detect");
  a_fwd_answer: assert property (fwd_valid |=> fwd_done)
    else $error("forward decision missing");
endmodule // cbbc_bridge_ctrl_asserts

bind cbbc_bridge_ctrl cbbc_bridge_ctrl_asserts u_asserts (.*);

// ---- tb/cbbc_card_model.sv ----
module cbbc_card_model (
  input wire logic clk,
  input wire logic card_reset_n,
  input wire logic [3:0] ev,
  output logic card_irq_request = 1'b0,
  output logic card_system_error_n = 1'b1,
  output logic card_master_abort = 1'b0,
  output logic card_parity_detect = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====
  // card events
  // =====
  // a card held in reset stays silent, so the bench must release it first
  always @(posedge clk)
  begin
    card_irq_request <= card_reset_n & ev[0];
    card_system_error_n <= ~(card_reset_n & ev[1]);
    card_master_abort <= card_reset_n & ev[2];
    card_parity_detect <= card_reset_n & ev[3];
  end
endmodule // cbbc_card_model

// ---- tb/cbbc_bridge_ctrl_tb.sv ----
`define CHK(nm, e, g) n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s exp %h got %h", nm, e, g); end
module cbbc_bridge_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cbbc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, global_reset_n = 1'b1, host_reset_n = 1'b1;
  logic power_mgmt_event = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, serr_enable = 1'b1;
  logic burst_write_req = 1'b1, fwd_valid = 1'b0, fwd_is_io = 1'b0, fwd_in_window = 1'b0;
  logic [2:0] cfg_func = 3'h0;
  logic [7:0] cfg_addr = 8'h3C;
  logic [3:0] cfg_byte_en = 4'h0, legacy_irq_num = 4'h5, ev = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000, fwd_addr = 32'h0000_0000;
  logic [CBBC_CFG_W-1:0] cfg_rdata;
  logic [CBBC_IRQ_LINES-1:0] legacy_irq_req;
  logic cfg_rvalid, write_post_enable, window1_prefetchable, window0_prefetchable;
  logic post_write_grant, fwd_done, fwd_to_card, pci_int_req, card_reset_n;
  logic pci_target_abort, pci_serr_n, card_parity_error_n, card_irq_request;
  logic card_system_error_n, card_master_abort, card_parity_detect;
  logic [15:0] v;
  int bad_count = 0, n_compared = 0, cyc = 0;
  // lanes, write data, expected readback
  logic [33:0] rows [6] = '{{2'h3, 16'hFFFF, 16'h07EF}, {2'h3, 16'h0000, 16'h0000},
    {2'h1, 16'hFFFF, 16'h00EF}, {2'h2, 16'hF8BF, 16'h00EF}, {2'h2, 16'h5A5A, 16'h02EF},
    {2'h3, 16'h0340, 16'h0340}};
  // bits 3:2, address, io, in window, expected decision
  logic [36:0] fwds [8] = '{{2'h1, 32'h0000_0100, 3'b110}, {2'h1, 32'h0000_04FF, 3'b111},
    {2'h1, 32'h0001_0100, 3'b111}, {2'h0, 32'h0000_0100, 3'b111},
    {2'h1, 32'h0000_03FF, 3'b110}, {2'h3, 32'h0000_03C0, 3'b101},
    {2'h2, 32'h000A_0000, 3'b001}, {2'h0, 32'h000A_0000, 3'b000}};
  logic [15:0] errs [2] = '{16'h0023, 16'h0000};

  cbbc_bridge_ctrl DUT (.*);
  cbbc_card_model card (.clk(clk), .card_reset_n(card_reset_n), .ev(ev),
    .card_irq_request(card_irq_request), .card_system_error_n(card_system_error_n),
    .card_master_abort(card_master_abort), .card_parity_detect(card_parity_detect));

  // =====
  // clock, watchdog, verdict
  // =====
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // =====
  // bus and event tasks
  // =====
  task automatic cw(input logic [1:0] be, input logic [15:0] d);
    cfg_wr = 1'b1;
    cfg_byte_en = {be, 2'b00};
    cfg_wdata = {d, 16'h0000};
    @(posedge clk);
    #1 cfg_wr = 1'b0;
  endtask
  task automatic cr(input logic [2:0] f, input logic [7:0] a);
    cfg_rd = 1'b1;
    cfg_func = f;
    cfg_addr = a;
    @(posedge clk);
    #1 cfg_rd = 1'b0;
    // the read answer stands for one cycle only, so it is taken right after the strobe's edge
    `CHK("read valid", 1'b1, cfg_rvalid)
    v = cfg_rdata[31:16];
    cfg_func = 3'h0;
    cfg_addr = 8'h3C;
    // one idle edge keeps a following strobe from being reraised in this time step
    @(posedge clk);
    #1;
  endtask
  // the card model adds one cycle ahead of the bridge's own registered cycle
  task automatic go(input logic [3:0] e);
    ev = e;
    @(posedge clk);
    #1 ev = 4'h0;
    @(posedge clk);
    #1;
  endtask
  // =====
  // main sequence
  // =====
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    cr(3'h0, 8'h3C);
    `CHK("reset value", 16'h0340, v)
    `CHK("card reset", 1'b0, card_reset_n)
    cr(3'h1, 8'h3C);
    `CHK("other function", 16'h0000, v)
    cr(3'h0, 8'h40);
    `CHK("unmapped", 16'h0000, v)
    foreach (rows[i])
    begin
      cw(rows[i][33:32], rows[i][31:16]);
      cr(3'h0, 8'h3C);
      `CHK("ctrl", rows[i][15:0], v)
      `CHK("posting", rows[i][10], write_post_enable)
      `CHK("grant", rows[i][10], post_write_grant)
      `CHK("window1", rows[i][9], window1_prefetchable)
      `CHK("window0", rows[i][8], window0_prefetchable)
      `CHK("card reset", ~rows[i][6], card_reset_n)
    end
    for (int p = 0; p < 2; p++)
    begin
      cw(2'h3, 16'h002F);
      power_mgmt_event = p[0];
      host_reset_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("host reset card_reset_n", 1'b0, card_reset_n)
      host_reset_n = 1'b1;
      cr(3'h0, 8'h3C);
      `CHK("after host reset", 16'h0300, v)
      `CHK("card_reset_n released", 1'b1, card_reset_n)
    end
    cw(2'h3, 16'h0000);
    global_reset_n = 1'b0;
    @(posedge clk);
    #1 global_reset_n = 1'b1;
    cr(3'h0, 8'h3C);
    `CHK("after global reset", 16'h0340, v)
    foreach (fwds[i])
    begin
      cw(2'h1, {12'h000, fwds[i][36:35], 2'b00});
      fwd_valid = 1'b1;
      {fwd_addr, fwd_is_io, fwd_in_window} = fwds[i][34:1];
      @(posedge clk);
      #1 fwd_valid = 1'b0;
      `CHK("fwd done", 1'b1, fwd_done)
      `CHK("fwd decision", fwds[i][0], fwd_to_card)
    end
    foreach (errs[i])
    begin
      cw(2'h3, errs[i]);
      go(4'h4);
      `CHK("target abort", errs[i][5], pci_target_abort)
      `CHK("abort serr", ~errs[i][5], pci_serr_n)
      go(4'h2);
      `CHK("card serr", ~errs[i][1], pci_serr_n)
      go(4'h8);
      `CHK("parity", ~errs[i][0], card_parity_error_n)
    end
    for (int b = 0; b < 2; b++)
    begin
      cw(2'h1, {8'h00, b[0], 7'h00});
      go(4'h1);
      `CHK("pci irq", ~b[0], pci_int_req)
      `CHK("legacy irq", b[0] ? 16'h0020 : 16'h0000, legacy_irq_req)
    end
    test_done();
  end
endmodule // cbbc_bridge_ctrl_tb
